/* verilog/umd_pkg.sv */
`default_nettype none
package umd_pkg;

	// ==========================================
	// Address widths
	localparam int ADDR_W = 40;
	localparam int PHYS_W = 36;
	localparam int MB_W   = 16;
	localparam int MB_SH  = 20;
	localparam int APB_AW = 8;

	// ==========================================
	// Fixed ranges
	localparam logic [ADDR_W-1:0] IOAPIC_LO = 40'h00_fec0_0000;
	localparam logic [ADDR_W-1:0] IOAPIC_HI = 40'h00_fec7_0fff;
	localparam logic [ADDR_W-1:0] HIGH_MGMT_WINDOW_LO   = 40'h00_feda_0000;
	localparam logic [ADDR_W-1:0] HIGH_MGMT_WINDOW_HI   = 40'h00_fedb_ffff;
	localparam logic [ADDR_W-1:0] MSI_LO    = 40'h00_fee0_0000;
	localparam logic [ADDR_W-1:0] MSI_HI    = 40'h00_feef_ffff;
	localparam logic [ADDR_W-1:0] BIOS_LO   = 40'h00_ffe0_0000;
	localparam logic [ADDR_W-1:0] BIOS_HI   = 40'h00_ffff_ffff;
	localparam logic [PHYS_W-1:0] LEGACY_VID = 36'h0_000a_0000;

	// ==========================================
	// Control bits
	localparam int CTRL_W          = 5;
	localparam int CTRL_HIGH_MGMT_WINDOW       = 0;
	localparam int CTRL_RECLAIM    = 1;
	localparam int CTRL_BRIDGE_MEM = 2;
	localparam int CTRL_GFX        = 3;
	localparam int CTRL_PCIE_CFG   = 4;

	// ==========================================
	// Register offsets
	localparam logic [APB_AW-1:0] OFF_CTRL      = 8'h00;
	localparam logic [APB_AW-1:0] OFF_TOM       = 8'h04;
	localparam logic [APB_AW-1:0] OFF_ME_STOLEN = 8'h08;
	localparam logic [APB_AW-1:0] OFF_TOP_LOW_USABLE_MEM     = 8'h0c;
	localparam logic [APB_AW-1:0] OFF_RBASE     = 8'h10;
	localparam logic [APB_AW-1:0] OFF_RLIMIT    = 8'h14;
	localparam logic [APB_AW-1:0] OFF_PCIE_CFG  = 8'h18;
	localparam logic [APB_AW-1:0] OFF_NP_BASE   = 8'h1c;
	localparam logic [APB_AW-1:0] OFF_NP_LIMIT  = 8'h20;
	localparam logic [APB_AW-1:0] OFF_PF_BASE   = 8'h24;
	localparam logic [APB_AW-1:0] OFF_PF_LIMIT  = 8'h28;
	localparam logic [APB_AW-1:0] OFF_GFX_REG   = 8'h2c;
	localparam logic [APB_AW-1:0] OFF_GFX_APER  = 8'h30;
	localparam logic [APB_AW-1:0] OFF_GFX_TBL   = 8'h34;
	localparam logic [APB_AW-1:0] OFF_TOP_UPPER_USABLE_MEM     = 8'h38;
	localparam logic [APB_AW-1:0] OFF_ME_BASE   = 8'h3c;
	localparam logic [APB_AW-1:0] OFF_STATUS    = 8'h40;

	// ==========================================
	// Window indices for the comparator bank
	localparam int WIN_NP   = 0;
	localparam int WIN_PF   = 1;
	localparam int WIN_GREG = 2;
	localparam int WIN_APER = 3;
	localparam int WIN_TBL  = 4;
	localparam int WIN_RECL = 5;
	localparam int NUM_WIN  = 6;

	typedef enum logic [1:0] {SRC_CPU, SRC_PCIE, SRC_GFX, SRC_LINK} umd_src_e;
	typedef enum logic [2:0] {TGT_NONE, TGT_DRAM, TGT_LINK, TGT_PCIE, TGT_GFX, TGT_CPU} umd_tgt_e;
	typedef enum logic [2:0] {KIND_MEM, KIND_CFG, KIND_MSI, KIND_INVALID, KIND_ABORT} umd_kind_e;

	typedef struct packed {
		logic              valid;
		umd_src_e          src;
		logic              write;
		logic              system_management_mode;
		logic              wb;
		logic [ADDR_W-1:0] addr;
	} umd_req_s;

	typedef struct packed {
		logic              valid;
		umd_tgt_e          tgt;
		umd_kind_e         kind;
		logic [PHYS_W-1:0] addr;
		logic [MB_W-1:0]   bdf;
	} umd_rsp_s;

	typedef struct packed {
		logic [CTRL_W-1:0] ctrl;
		logic [MB_W-1:0]   installed_memory_top;
		logic [MB_W-1:0]   me_stolen;
		logic [MB_W-1:0]   top_low_usable_mem;
		logic [MB_W-1:0]   rbase;
		logic [MB_W-1:0]   rlimit;
		logic [3:0]        pcie_cfg;
		logic [MB_W-1:0]   np_base;
		logic [MB_W-1:0]   np_limit;
		logic [MB_W-1:0]   pf_base;
		logic [MB_W-1:0]   pf_limit;
		logic [MB_W-1:0]   gfx_reg;
		logic [MB_W-1:0]   gfx_aper;
		logic [MB_W-1:0]   gfx_tbl;
	} umd_cfg_s;

endpackage
`default_nettype wire

/* verilog/umd_win_cmp.sv */
`timescale 1ns/100ps
`default_nettype none
module umd_win_cmp
	import umd_pkg::*;
#(
	parameter int N = NUM_WIN,
	parameter int W = MB_W
) (
	input  wire logic [W-1:0]        addr_i,
	input  wire logic [N-1:0][W-1:0] base_i,
	input  wire logic [N-1:0][W-1:0] limit_i,
	output logic      [N-1:0]        hit_o
);

	// ==========================================
	// Inclusive compare at both ends
	always_comb begin
		for (int i = 0; i < N; i++) begin
			hit_o[i] = (addr_i >= base_i[i]) && (addr_i <= limit_i[i]);
		end
	end

endmodule
`default_nettype wire

/* verilog/umd_decoder.sv */
// Notes on behaviour
// [R1] Interrupt-controller config range goes to downstream link, 4 KB per unit 0-F; the code decodes only up to IOAPIC_HI, the end of unit 7.
// [R2] Interrupt-controller config accesses never go to PCI Express.
// [R3] Enabled high window in management mode remaps to low DRAM at video base.
// [R4] Enabled high window outside management mode is aborted at once, write-backs excepted.
// [R5] Write-back line writes to high window complete to DRAM like management cycles.
// [R6] Upstream cycles to enabled management space are refused, never reach it.
// [R7] DRAM at the high window's own addresses is never reachable.
// [R8] Upstream writes to the interrupt message range go to processor bus, never DRAM.
// [R9] Device ends each interrupt message itself and asserts target ready.
// [R10] Top 2 MB boot area goes to downstream link.
// [R11] Upstream addresses beyond 36 bits are invalid cycles.
// [R12] Top upper usable memory is top minus stolen, or reclaim limit when reclaiming.
// [R13] Software sets reclaim base to top minus stolen, 64-MB aligned.
// [R14] Stolen region base is installed top minus stolen size.
// [R15] Addresses inside the reclaim window go to memory from low usable top.
// [R16] Software aligns low usable top to 64 MB when reclaiming, else 1 MB.
// [R17] Config window is a 256-MB aligned block below 4 GB, upper bits only.
// [R18] Software keeps the config window clear of all other ranges.
// [R19] Both bridge memory windows claim for PCI Express, inclusive at both ends.
// [R20] Bridge windows decode only while the memory-access enable bit is set.
// [R21] No aperture translation and no aperture registers.
// [R22] Graphics register, aperture and table windows go to integrated graphics.
// [R23] Unmatched addresses between low usable top and 4 GB go to downstream link.
// [R24] Config window accesses go out as config cycles by bus, device, function.
// [R25] Remapped address is address minus reclaim base plus low usable top.
// [R26] Fixed ranges first, then programmable windows, then default link.
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module umd_decoder
	import umd_pkg::*;
#(
	parameter int GFX_REG_MB  = 1,
	parameter int GFX_APER_MB = 256,
	parameter int GFX_TBL_MB  = 1
) (
	input  wire logic              clk_i,
	input  wire logic              sys_rst_i,
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [APB_AW-1:0] paddr_i,
	input  wire logic [31:0]       pwdata_i,
	output logic      [31:0]       prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	input  wire umd_req_s          req_i,
	output umd_rsp_s               rsp_o,
	output logic                   target_ready_n_o
);

	// ==========================================
	// State
	typedef struct packed {
		umd_cfg_s        cfg;
		logic [MB_W-1:0] top_upper_usable_mem;
		logic [MB_W-1:0] me_base;
		umd_rsp_s        rsp;
		logic            trdy_n;
		logic [7:0]      bad_cnt;
		logic [31:0]     prdata;
		logic            pready;
		logic            pslverr;
	} umd_state_s;

	localparam logic [MB_W-1:0] GREG_SPAN = MB_W'(GFX_REG_MB - 1);
	localparam logic [MB_W-1:0] APER_SPAN = MB_W'(GFX_APER_MB - 1);
	localparam logic [MB_W-1:0] TBL_SPAN  = MB_W'(GFX_TBL_MB - 1);

	umd_state_s st;
	umd_state_s next_st;

	function automatic logic in_rng(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] lo, input logic [ADDR_W-1:0] hi);
		in_rng = (a >= lo) && (a <= hi);
	endfunction

	// ==========================================
	// Window bank
	logic [MB_W-1:0]                 a_mb;
	logic [NUM_WIN-1:0][MB_W-1:0]    win_lo;
	logic [NUM_WIN-1:0][MB_W-1:0]    win_hi;
	logic [NUM_WIN-1:0]              win_hit;

	assign a_mb = req_i.addr[PHYS_W-1:MB_SH];

	always_comb begin
		win_lo[WIN_NP]   = st.cfg.np_base;
		win_hi[WIN_NP]   = st.cfg.np_limit;
		win_lo[WIN_PF]   = st.cfg.pf_base;
		win_hi[WIN_PF]   = st.cfg.pf_limit;
		win_lo[WIN_GREG] = st.cfg.gfx_reg;
		win_hi[WIN_GREG] = st.cfg.gfx_reg + GREG_SPAN;
		win_lo[WIN_APER] = st.cfg.gfx_aper;
		win_hi[WIN_APER] = st.cfg.gfx_aper + APER_SPAN;
		win_lo[WIN_TBL]  = st.cfg.gfx_tbl;
		win_hi[WIN_TBL]  = st.cfg.gfx_tbl + TBL_SPAN;
		win_lo[WIN_RECL] = st.cfg.rbase;
		win_hi[WIN_RECL] = st.cfg.rlimit;
	end

	umd_win_cmp #(
		.N (NUM_WIN),
		.W (MB_W)
	) u_win (
		.addr_i  (a_mb),
		.base_i  (win_lo),
		.limit_i (win_hi),
		.hit_o   (win_hit)
	);

	// ==========================================
	// Decode helpers
	logic up;
	logic high_mgmt_window_on;
	logic below_4g;
	logic cfg_hit;

	assign up       = (req_i.src != SRC_CPU);
	assign high_mgmt_window_on  = st.cfg.ctrl[CTRL_HIGH_MGMT_WINDOW];
	assign below_4g = (req_i.addr[ADDR_W-1:32] == '0);
	assign cfg_hit  = st.cfg.ctrl[CTRL_PCIE_CFG] && below_4g
		&& (req_i.addr[31:28] == st.cfg.pcie_cfg);

	// ==========================================
	// Next state
	always_comb begin
		next_st = st;
		next_st.pready = 1'b0;
		next_st.pslverr = 1'b0;
		next_st.prdata = '0;
		// [R12] Upper usable top
		next_st.top_upper_usable_mem = st.cfg.ctrl[CTRL_RECLAIM] ? st.cfg.rlimit
			: (st.cfg.installed_memory_top - st.cfg.me_stolen);
		// [R14] Stolen region base
		next_st.me_base = st.cfg.installed_memory_top - st.cfg.me_stolen;

		// One wait state: answer is prepared in the first access cycle
		if (psel_i && penable_i && !st.pready) begin
			next_st.pready = 1'b1;
			case (paddr_i)
				OFF_CTRL: begin
					next_st.prdata = 32'(st.cfg.ctrl);
				end
				OFF_TOM: begin
					next_st.prdata = 32'(st.cfg.installed_memory_top);
				end
				OFF_ME_STOLEN: begin
					next_st.prdata = 32'(st.cfg.me_stolen);
				end
				OFF_TOP_LOW_USABLE_MEM: begin
					next_st.prdata = 32'(st.cfg.top_low_usable_mem);
				end
				OFF_RBASE: begin
					next_st.prdata = 32'(st.cfg.rbase);
				end
				OFF_RLIMIT: begin
					next_st.prdata = 32'(st.cfg.rlimit);
				end
				OFF_PCIE_CFG: begin
					next_st.prdata = 32'(st.cfg.pcie_cfg);
				end
				OFF_NP_BASE: begin
					next_st.prdata = 32'(st.cfg.np_base);
				end
				OFF_NP_LIMIT: begin
					next_st.prdata = 32'(st.cfg.np_limit);
				end
				OFF_PF_BASE: begin
					next_st.prdata = 32'(st.cfg.pf_base);
				end
				OFF_PF_LIMIT: begin
					next_st.prdata = 32'(st.cfg.pf_limit);
				end
				OFF_GFX_REG: begin
					next_st.prdata = 32'(st.cfg.gfx_reg);
				end
				OFF_GFX_APER: begin
					next_st.prdata = 32'(st.cfg.gfx_aper);
				end
				OFF_GFX_TBL: begin
					next_st.prdata = 32'(st.cfg.gfx_tbl);
				end
				OFF_TOP_UPPER_USABLE_MEM: begin
					next_st.prdata = 32'(st.top_upper_usable_mem);
				end
				OFF_ME_BASE: begin
					next_st.prdata = 32'(st.me_base);
				end
				OFF_STATUS: begin
					next_st.prdata = {18'h0, st.bad_cnt, st.rsp.kind, st.rsp.tgt};
				end
				default: begin
					next_st.pslverr = 1'b1;
				end
			endcase
		end

		// Writes land only at the completing edge
		if (psel_i && penable_i && st.pready && pwrite_i) begin
			case (paddr_i)
				OFF_CTRL: begin
					next_st.cfg.ctrl = pwdata_i[CTRL_W-1:0];
				end
				OFF_TOM: begin
					next_st.cfg.installed_memory_top = pwdata_i[MB_W-1:0];
				end
				OFF_ME_STOLEN: begin
					next_st.cfg.me_stolen = pwdata_i[MB_W-1:0];
				end
				OFF_TOP_LOW_USABLE_MEM: begin
					next_st.cfg.top_low_usable_mem = pwdata_i[MB_W-1:0];
				end
				OFF_RBASE: begin
					next_st.cfg.rbase = pwdata_i[MB_W-1:0];
				end
				OFF_RLIMIT: begin
					next_st.cfg.rlimit = pwdata_i[MB_W-1:0];
				end
				OFF_PCIE_CFG: begin
					next_st.cfg.pcie_cfg = pwdata_i[3:0];
				end
				OFF_NP_BASE: begin
					next_st.cfg.np_base = pwdata_i[MB_W-1:0];
				end
				OFF_NP_LIMIT: begin
					next_st.cfg.np_limit = pwdata_i[MB_W-1:0];
				end
				OFF_PF_BASE: begin
					next_st.cfg.pf_base = pwdata_i[MB_W-1:0];
				end
				OFF_PF_LIMIT: begin
					next_st.cfg.pf_limit = pwdata_i[MB_W-1:0];
				end
				OFF_GFX_REG: begin
					next_st.cfg.gfx_reg = pwdata_i[MB_W-1:0];
				end
				OFF_GFX_APER: begin
					next_st.cfg.gfx_aper = pwdata_i[MB_W-1:0];
				end
				OFF_GFX_TBL: begin
					next_st.cfg.gfx_tbl = pwdata_i[MB_W-1:0];
				end
				default: begin
				end
			endcase
		end

		// [R26] Route priority
		next_st.rsp.valid = req_i.valid;
		next_st.rsp.tgt = TGT_LINK;
		next_st.rsp.kind = KIND_MEM;
		next_st.rsp.addr = req_i.addr[PHYS_W-1:0];
		next_st.rsp.bdf = '0;
		// [R11] Beyond 36 bits
		if (up && (req_i.addr[ADDR_W-1:PHYS_W] != '0)) begin
			next_st.rsp.tgt = TGT_NONE;
			next_st.rsp.kind = KIND_INVALID;
		// [R1] [R2] Interrupt-controller units
		end else if (in_rng(req_i.addr, IOAPIC_LO, IOAPIC_HI)) begin
			next_st.rsp.tgt = TGT_LINK;
		// [R8] Interrupt messages
		end else if (up && in_rng(req_i.addr, MSI_LO, MSI_HI)) begin
			next_st.rsp.tgt = req_i.write ? TGT_CPU : TGT_NONE;
			next_st.rsp.kind = req_i.write ? KIND_MSI : KIND_INVALID;
		end else if (high_mgmt_window_on && in_rng(req_i.addr, HIGH_MGMT_WINDOW_LO, HIGH_MGMT_WINDOW_HI)) begin
			if (up) begin
				// [R6] Upstream refused
				next_st.rsp.tgt = TGT_NONE;
				next_st.rsp.kind = KIND_INVALID;
			end else if (req_i.system_management_mode || req_i.wb) begin
				// [R3] [R5] [R7] Remap to video base
				next_st.rsp.tgt = TGT_DRAM;
				next_st.rsp.addr = LEGACY_VID
					+ (req_i.addr[PHYS_W-1:0] - HIGH_MGMT_WINDOW_LO[PHYS_W-1:0]);
			end else begin
				// [R4] Terminated at once
				next_st.rsp.tgt = TGT_NONE;
				next_st.rsp.kind = KIND_ABORT;
			end
		// [R10] Boot area
		end else if (in_rng(req_i.addr, BIOS_LO, BIOS_HI)) begin
			next_st.rsp.tgt = TGT_LINK;
		// [R17] [R24] Config window
		end else if (cfg_hit) begin
			next_st.rsp.tgt = TGT_PCIE;
			next_st.rsp.kind = KIND_CFG;
			next_st.rsp.bdf = req_i.addr[27:12];
		// [R19] [R20] [R21] Bridge windows, untranslated
		end else if (st.cfg.ctrl[CTRL_BRIDGE_MEM] && (win_hit[WIN_NP] || win_hit[WIN_PF])) begin
			next_st.rsp.tgt = TGT_PCIE;
		// [R22] Graphics windows
		end else if (st.cfg.ctrl[CTRL_GFX]
			&& (win_hit[WIN_GREG] || win_hit[WIN_APER] || win_hit[WIN_TBL])) begin
			next_st.rsp.tgt = TGT_GFX;
		// [R15] [R25] Reclaim window
		end else if (st.cfg.ctrl[CTRL_RECLAIM] && win_hit[WIN_RECL]) begin
			next_st.rsp.tgt = TGT_DRAM;
			next_st.rsp.addr = {a_mb - st.cfg.rbase + st.cfg.top_low_usable_mem,
				req_i.addr[MB_SH-1:0]};
		end else if (below_4g && (a_mb < st.cfg.top_low_usable_mem)) begin
			next_st.rsp.tgt = TGT_DRAM;
		end else if (!below_4g && (a_mb < st.top_upper_usable_mem)) begin
			next_st.rsp.tgt = TGT_DRAM;
		end else begin
			// [R23] Default link
			next_st.rsp.tgt = TGT_LINK;
		end
		if (!req_i.valid) begin
			next_st.rsp.tgt = TGT_NONE;
		end

		// [R9] Message closed by this device
		next_st.trdy_n = !(req_i.valid && next_st.rsp.kind == KIND_MSI);
		if (req_i.valid && (next_st.rsp.kind == KIND_INVALID || next_st.rsp.kind == KIND_ABORT)) begin
			next_st.bad_cnt = st.bad_cnt + 8'h01;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st <= '0;
			st.trdy_n <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign prdata_o = st.prdata;
	assign pready_o = st.pready;
	assign pslverr_o = st.pslverr;
	assign rsp_o = st.rsp;
	assign target_ready_n_o = st.trdy_n;

	// ==========================================
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	logic p_ioapic;
	logic p_high_mgmt_window;
	assign p_ioapic = req_i.valid && in_rng(req_i.addr, IOAPIC_LO, IOAPIC_HI);
	assign p_high_mgmt_window = req_i.valid && high_mgmt_window_on && in_rng(req_i.addr, HIGH_MGMT_WINDOW_LO, HIGH_MGMT_WINDOW_HI);

	ioapic_link_a: assert property (p_ioapic |=> rsp_o.tgt == TGT_LINK) // [R1]
		else $error("interrupt-controller access not on link");
	ioapic_pcie_a: assert property (p_ioapic |=> rsp_o.tgt != TGT_PCIE && rsp_o.kind == KIND_MEM) // [R2]
		else $error("interrupt-controller access sent to pcie");
	high_mgmt_window_smm_a: assert property (p_high_mgmt_window && !up && req_i.system_management_mode && !req_i.addr[39] |=> // [R3]
		rsp_o.tgt == TGT_DRAM && rsp_o.addr == LEGACY_VID + ($past(req_i.addr[PHYS_W-1:0]) - HIGH_MGMT_WINDOW_LO[PHYS_W-1:0]))
		else $error("management window remap wrong");
	high_mgmt_window_abort_a: assert property (p_high_mgmt_window && !up && !req_i.system_management_mode && !req_i.wb |=> // [R4]
		rsp_o.kind == KIND_ABORT && rsp_o.tgt == TGT_NONE)
		else $error("non-management access not aborted");
	high_mgmt_window_wb_a: assert property (p_high_mgmt_window && !up && req_i.wb |=> rsp_o.tgt == TGT_DRAM) // [R5]
		else $error("write-back to window not sent to dram");
	high_mgmt_window_up_a: assert property (p_high_mgmt_window && up |=> rsp_o.kind == KIND_INVALID) // [R6]
		else $error("upstream management access not refused");
	msi_fwd_a: assert property (req_i.valid && up && req_i.write && req_i.addr[ADDR_W-1:PHYS_W] == '0 // [R8]
		&& in_rng(req_i.addr, MSI_LO, MSI_HI) |=> rsp_o.tgt == TGT_CPU && !target_ready_n_o)
		else $error("interrupt message not forwarded");
	msi_trdy_a: assert property (!target_ready_n_o |-> rsp_o.kind == KIND_MSI) // [R9]
		else $error("target ready without message");
	wide_addr_a: assert property (req_i.valid && up && req_i.addr[ADDR_W-1:PHYS_W] != '0 // [R11]
		|=> rsp_o.kind == KIND_INVALID)
		else $error("wide upstream address accepted");
	top_upper_usable_mem_a: assert property ($stable(st.cfg) [*2] |-> st.top_upper_usable_mem == // [R12]
		(st.cfg.ctrl[CTRL_RECLAIM] ? st.cfg.rlimit : st.cfg.installed_memory_top - st.cfg.me_stolen))
		else $error("upper usable top wrong");
	bridge_off_a: assert property (!st.cfg.ctrl[CTRL_BRIDGE_MEM] && !cfg_hit |=> rsp_o.tgt != TGT_PCIE) // [R20]
		else $error("bridge window decoded while disabled");
	apb_wait_a: assert property (psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o)
		else $error("apb answer timing wrong");

	msi_c: cover property (!target_ready_n_o);
	abort_c: cover property (rsp_o.kind == KIND_ABORT);
	cfg_c: cover property (rsp_o.kind == KIND_CFG);
	recl_c: cover property (st.cfg.ctrl[CTRL_RECLAIM] && win_hit[WIN_RECL] && req_i.valid);

endmodule
`default_nettype wire

/* test/umd_req_agent.sv */
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Processor bus and upstream requester model
module umd_req_agent
	import umd_pkg::*;
(
	input  wire logic clk_i,
	output umd_req_s  req_o
);
	initial req_o = '0;

	// ==========================================
	// One request per call
	// Valid stands for exactly one sampling edge; the idle address is inverted so stale values never match
	task automatic issue(input umd_src_e s, input logic w, input logic sm, input logic wb,
		input logic [ADDR_W-1:0] a);
		begin
			@(posedge clk_i);
			req_o <= '{valid: 1'b1, src: s, write: w, system_management_mode: sm, wb: wb, addr: a};
			@(posedge clk_i);
			req_o <= '{valid: 1'b0, src: s, write: ~w, system_management_mode: ~sm, wb: ~wb, addr: ~a};
		end
	endtask
endmodule
`default_nettype wire

/* test/tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb
	import umd_pkg::*;
;
	logic              clk, rst, psel, penable, pwrite;
	logic [APB_AW-1:0] paddr;
	logic [31:0]       pwdata, prdata;
	logic              pready, pslverr, trdy_n;
	umd_req_s          req;
	umd_rsp_s          rsp;
	int                fails, num_checks;

	umd_decoder umd_decoder_inst (.clk_i(clk), .sys_rst_i(rst), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .req_i(req), .rsp_o(rsp), .target_ready_n_o(trdy_n));
	umd_req_agent umd_req_agent_inst (.clk_i(clk), .req_o(req));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ==========================================
	// Reporting
	task automatic conclude;
		begin
			$display("checks %0d mismatches %0d", num_checks, fails);
			if (fails == 0 && num_checks > 0) begin
				$display("All tests passed");
			end else begin
				$display("Some tests failed");
			end
			$finish;
		end
	endtask

	task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
		begin
			num_checks++;
			if (got !== exp) begin
				fails++;
				$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
			end
		end
	endtask

	// ==========================================
	// Register bus master
	// Request held until pready is seen high at a rising edge; bounded so a dead slave ends the run
	task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		begin
			@(posedge clk);
			psel <= 1'b1;
			penable <= 1'b0;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge clk);
			penable <= 1'b1;
			n = 0;
			// Sampled at the rising edge itself, so prdata below is the value that stands with pready
			do begin
				@(posedge clk);
				n++;
			end while (pready !== 1'b1 && n < 16);
			if (pready !== 1'b1) begin
				fails++;
				$display("wrong value at %0t: no ready", $time);
				conclude();
			end
			q = prdata;
			e = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	task automatic wr(input logic [APB_AW-1:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		begin
			apb(1'b1, a, d, q, e);
		end
	endtask

	task automatic rd(input logic [APB_AW-1:0] a, input logic [31:0] x, input logic xe);
		logic [31:0] q;
		logic        e;
		begin
			apb(1'b0, a, 32'h0, q, e);
			chk({8'h0, q}, {8'h0, x}, "read data");
			chk({39'h0, e}, {39'h0, xe}, "error flag");
		end
	endtask

	// ==========================================
	// Request path: answer checked 1 ns after the edge that samples the request
	task automatic rq(input umd_src_e s, input logic w, input logic sm, input logic wb,
		input logic [ADDR_W-1:0] a, input umd_tgt_e t, input umd_kind_e k,
		input logic [PHYS_W-1:0] ea, input logic ca);
		begin
			umd_req_agent_inst.issue(s, w, sm, wb, a);
			#1;
			chk({39'h0, rsp.valid}, 40'h1, "valid");
			chk({37'h0, rsp.tgt}, {37'h0, t}, "target");
			if (k == KIND_CFG) begin
				chk({24'h0, rsp.bdf}, {24'h0, a[27:12]}, "bdf");
			end
			chk({37'h0, rsp.kind}, {37'h0, k}, "kind");
			chk({39'h0, trdy_n}, {39'h0, k != KIND_MSI}, "target ready");
			if (ca) begin
				chk({4'h0, rsp.addr}, {4'h0, ea}, "address");
			end
		end
	endtask

	// ==========================================
	// Main sequence
	initial begin
		fails = 0;
		num_checks = 0;
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		#1;
		chk({39'h0, trdy_n}, 40'h1, "idle target ready");
		chk({39'h0, rsp.valid}, 40'h0, "idle valid");
		rd(OFF_CTRL, 32'h0, 1'b0);
		rd(OFF_TOP_UPPER_USABLE_MEM, 32'h0, 1'b0);
		// Memory map: 6 GB installed, 64 MB stolen, low top 3 GB, 1 GB reclaimed
		wr(OFF_TOM, 32'h1800);
		wr(OFF_ME_STOLEN, 32'h40);
		wr(OFF_TOP_LOW_USABLE_MEM, 32'hc00);
		wr(OFF_RBASE, 32'h17c0);
		wr(OFF_RLIMIT, 32'h1bbf);
		wr(OFF_PCIE_CFG, 32'he);
		wr(OFF_NP_BASE, 32'hd00);
		wr(OFF_NP_LIMIT, 32'hd0f);
		wr(OFF_PF_BASE, 32'hd10);
		wr(OFF_PF_LIMIT, 32'hd3f);
		wr(OFF_GFX_REG, 32'hd80);
		wr(OFF_GFX_APER, 32'hc00);
		wr(OFF_GFX_TBL, 32'hd90);
		rd(OFF_TOP_UPPER_USABLE_MEM, 32'h17c0, 1'b0);
		rd(OFF_ME_BASE, 32'h17c0, 1'b0);
		wr(OFF_CTRL, 32'h1f);
		rd(OFF_TOP_UPPER_USABLE_MEM, 32'h1bbf, 1'b0);
		wr(OFF_TOP_UPPER_USABLE_MEM, 32'h1234);
		rd(OFF_TOP_UPPER_USABLE_MEM, 32'h1bbf, 1'b0);
		rd(8'h44, 32'h0, 1'b1);
		rq(SRC_CPU, 0, 0, 0, 40'hfec0_3000, TGT_LINK, KIND_MEM, 0, 0);
		rq(SRC_CPU, 1, 0, 0, 40'hfec7_0fff, TGT_LINK, KIND_MEM, 0, 0);
		rq(SRC_PCIE, 1, 0, 0, 40'hfec7_0000, TGT_LINK, KIND_MEM, 0, 0);
		rq(SRC_CPU, 0, 1, 0, 40'hfeda_1234, TGT_DRAM, KIND_MEM, 36'ha_1234, 1);
		rq(SRC_CPU, 1, 1, 0, 40'hfedb_fff0, TGT_DRAM, KIND_MEM, 36'hb_fff0, 1);
		rq(SRC_CPU, 0, 0, 0, 40'hfeda_0000, TGT_NONE, KIND_ABORT, 0, 0);
		rq(SRC_CPU, 1, 0, 1, 40'hfeda_0040, TGT_DRAM, KIND_MEM, 36'ha_0040, 1);
		rq(SRC_PCIE, 0, 0, 0, 40'hfeda_0000, TGT_NONE, KIND_INVALID, 0, 0);
		rq(SRC_LINK, 1, 0, 1, 40'hfedb_0000, TGT_NONE, KIND_INVALID, 0, 0);
		rq(SRC_PCIE, 1, 0, 0, 40'hfee0_1000, TGT_CPU, KIND_MSI, 0, 0);
		rq(SRC_GFX, 1, 0, 0, 40'hfeef_fffc, TGT_CPU, KIND_MSI, 0, 0);
		rq(SRC_LINK, 1, 0, 0, 40'hfee0_0000, TGT_CPU, KIND_MSI, 0, 0);
		rq(SRC_PCIE, 0, 0, 0, 40'hfee0_0000, TGT_NONE, KIND_INVALID, 0, 0);
		rq(SRC_CPU, 0, 0, 0, 40'hffe0_0000, TGT_LINK, KIND_MEM, 0, 0);
		rq(SRC_CPU, 0, 0, 0, 40'hffff_fffc, TGT_LINK, KIND_MEM, 0, 0);
		rq(SRC_PCIE, 0, 0, 0, 40'h10_0000_0000, TGT_NONE, KIND_INVALID, 0, 0);
		rq(SRC_LINK, 1, 0, 0, 40'hff_ffff_f000, TGT_NONE, KIND_INVALID, 0, 0);
		rq(SRC_CPU, 0, 0, 0, 40'h01_7c12_3456, TGT_DRAM, KIND_MEM, 36'h0_c012_3456, 1);
		rq(SRC_PCIE, 1, 0, 0, 40'h01_bbff_ffff, TGT_DRAM, KIND_MEM, 36'h0_ffff_ffff, 1);
		rq(SRC_CPU, 0, 0, 0, 40'h00_e012_3000, TGT_PCIE, KIND_CFG, 0, 0);
		rq(SRC_CPU, 1, 0, 0, 40'h00_efff_f000, TGT_PCIE, KIND_CFG, 0, 0);
		rq(SRC_CPU, 0, 0, 0, 40'h00_f000_0000, TGT_LINK, KIND_MEM, 0, 0);
		// Bridge hits carry the address through untouched
		rq(SRC_CPU, 0, 0, 0, 40'h00_d000_0000, TGT_PCIE, KIND_MEM, 36'hd000_0000, 1);
		rq(SRC_CPU, 1, 0, 0, 40'h00_d0ff_ffff, TGT_PCIE, KIND_MEM, 36'hd0ff_ffff, 1);
		rq(SRC_CPU, 0, 0, 0, 40'h00_d3ff_ffff, TGT_PCIE, KIND_MEM, 36'hd3ff_ffff, 1);
		rq(SRC_CPU, 0, 0, 0, 40'h00_d400_0000, TGT_LINK, KIND_MEM, 0, 0);
		rq(SRC_CPU, 0, 0, 0, 40'h00_c000_0000, TGT_GFX, KIND_MEM, 0, 0);
		rq(SRC_CPU, 1, 0, 0, 40'h00_d80f_fffc, TGT_GFX, KIND_MEM, 0, 0);
		rq(SRC_CPU, 0, 0, 0, 40'h00_d900_0000, TGT_GFX, KIND_MEM, 0, 0);
		rq(SRC_CPU, 0, 0, 0, 40'h00_d910_0000, TGT_LINK, KIND_MEM, 0, 0);
		rq(SRC_CPU, 0, 0, 0, 40'h00_1000_0000, TGT_DRAM, KIND_MEM, 36'h1000_0000, 1);
		// High window, reclaim and bridge windows off
		wr(OFF_CTRL, 32'h18);
		rd(OFF_TOP_UPPER_USABLE_MEM, 32'h17c0, 1'b0);
		rq(SRC_CPU, 0, 0, 0, 40'h00_d000_0000, TGT_LINK, KIND_MEM, 0, 0);
		rq(SRC_CPU, 0, 1, 0, 40'h00_feda_0000, TGT_LINK, KIND_MEM, 0, 0);
		// Six refused or aborted requests so far; idle request leaves kind MEM, target NONE
		rd(OFF_STATUS, 32'h180, 1'b0);
		conclude();
	end
endmodule
`default_nettype wire
